// ---- src/csc_consts.svh ----
// named offsets, field positions, reset values and counts of the colour sensor register bank
`ifndef CSC_CONSTS_SVH
`define CSC_CONSTS_SVH

`define CSC_ADDR_IDENTITY 8'h01
`define CSC_ADDR_POWER 8'h04
`define CSC_ADDR_VERSION 8'h11
`define CSC_ADDR_IRQ_PIN 8'h22
`define CSC_ADDR_SETUP_ONE 8'h70
`define CSC_ADDR_SETUP_TWO 8'h71
`define CSC_ADDR_INDICATOR 8'h84
`define CSC_ADDR_SETUP_FOUR 8'h88
`define CSC_ADDR_SETUP_FIVE 8'h9a
`define CSC_ADDR_SETUP_THREE 8'hb0
`define CSC_ADDR_GAIN_DRIVE 8'hb9
`define CSC_ADDR_AUTOZERO 8'hba
`define CSC_ADDR_SHUTTER 8'hea
`define CSC_ADDR_IRQ_CLEAR 8'hf8
`define CSC_ADDR_READY_EN 8'hf9

`define CSC_ZERO_BYTE 8'h00
`define CSC_POWER_RST 8'h02
`define CSC_SETUP_RST 8'h00
`define CSC_IRQ_PIN_ON 8'hca

`define CSC_NORMAL_BIT 1
`define CSC_CLEAR_BIT 2
`define CSC_READY_HI 2
`define CSC_READY_LO 1
`define CSC_SHUTTER_ON_BIT 2
`define CSC_IND_ON_BIT 0
`define CSC_IND_CUR_HI 3
`define CSC_IND_CUR_LO 2
`define CSC_LIMIT_HI 7
`define CSC_LIMIT_LO 6
`define CSC_GAIN_HI 1
`define CSC_GAIN_LO 0
`define CSC_AZ_DONE_BIT 7
`define CSC_AZ_RESV_HI 6
`define CSC_AZ_RESV_LO 4
`define CSC_AZ_CHAN_HI 3
`define CSC_AZ_CHAN_LO 0

`define CSC_AZ_CYCLES 16
// arbitrary identity and version values
`define CSC_IDENTITY_VALUE 8'h5a
`define CSC_VERSION_VALUE 8'h01

`endif

// ---- src/csc_pkg.sv ----
// types shared by the colour sensor register bank
package csc_pkg;
  typedef logic [7:0] csc_byte_t;
  typedef enum logic {csc_az_idle, csc_az_run} csc_az_state_t;
endpackage

// ---- src/csc_autozero.sv ----
// manual offset calibration sequencer for the sensor channels
`timescale 1ns/1ns
`include "csc_consts.svh"
module csc_autozero #(
  parameter int unsigned CYCLES = `CSC_AZ_CYCLES,
  parameter int CHANNELS = 4
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [CHANNELS-1:0] i_start,
  output logic o_busy,
  output logic o_done,
  output logic [CHANNELS-1:0] o_active
);
  localparam int CW = $clog2(CYCLES + 1);
  csc_pkg::csc_az_state_t state;
  logic [CW-1:0] count;
  wire run_end = (state == csc_pkg::csc_az_run) && (count == '0);

  // start bits still standing in the done cycle are cleared there, so they must not relaunch
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state <= csc_pkg::csc_az_idle;
      count <= '0;
      o_active <= '0;
      o_done <= 1'b0;
    end
    else
    begin
      o_done <= run_end;
      unique case (state)
        csc_pkg::csc_az_idle:
        begin
          if (|i_start && !o_done)
          begin
            state <= csc_pkg::csc_az_run;
            o_active <= i_start;
            count <= CW'(CYCLES - 1);
          end
        end
        csc_pkg::csc_az_run:
        begin
          if (run_end)
          begin
            state <= csc_pkg::csc_az_idle;
            o_active <= '0;
          end
          else
            count <= count - 1'b1;
        end
      endcase
    end
  end

  assign o_busy = (state == csc_pkg::csc_az_run);

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  az_launch_a: assert property (
    !o_busy && !o_done && |i_start |=> o_busy && o_active == $past(i_start))
    else $error("auto-zero did not launch on start bits");
  az_finish_a: assert property (
    o_done |-> $past(o_busy) && !o_busy && o_active == '0)
    else $error("auto-zero done without a finished pass");
endmodule

// ---- src/csc_irq.sv ----
// data-ready latch and interrupt output gating
`timescale 1ns/1ns
module csc_irq (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_ready_en,
  input wire logic i_pin_en,
  input wire logic i_data_ready,
  input wire logic i_clear,
  output logic o_pending,
  output logic o_irq
);
  wire set_event = i_ready_en && i_data_ready;
  wire clear_event = i_ready_en && i_clear;

  // a fresh data-ready in the clear cycle wins so no sample is missed
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      o_pending <= 1'b0;
    else if (set_event)
      o_pending <= 1'b1;
    else if (clear_event)
      o_pending <= 1'b0;
  end

  assign o_irq = o_pending && i_pin_en && i_ready_en;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  irq_hold_a: assert property (
    o_pending && !clear_event |=> o_pending)
    else $error("pending data-ready dropped without a clear");
  clear_blocked_a: assert property (
    o_pending && i_clear && !i_ready_en |=> o_pending)
    else $error("clear acted while data-ready reporting was off");
endmodule

// ---- src/csc_regs.sv ----
// host-visible control register bank of the colour light sensor
// What this block does
// - power-mode bit 1 means normal, 0 low power; resets to 1
// - interrupt pin setup resets to 0x00, off; value 0xca enables the pin
// - writing the clear bit drops the interrupt, only while data-ready is enabled
// - clear bit reads 1 while data-ready reporting is enabled
// - enable field turns on data-ready signalling for polling or interrupt
// - shutter bit drives shutter LED at the chosen current limit; clear turns off
// - indicator current field picks 1, 2, 4 or 8 mA
// - indicator bit turns the indicator LED on at the chosen current
// - completion flag sets when any auto-zero pass finishes
// - writing a channel bit while no pass is busy or finishing starts auto-zero of that channel
// - channel start bits clear themselves when the completion flag sets
// - shutter limit field picks 100, 50, 25 or 12.5 mA
`timescale 1ns/1ns
`include "csc_consts.svh"
module csc_regs #(
  parameter int unsigned AZ_CYCLES = `CSC_AZ_CYCLES,
  parameter logic [7:0] IDENTITY = `CSC_IDENTITY_VALUE,
  parameter logic [7:0] VERSION = `CSC_VERSION_VALUE
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  input wire logic i_data_ready,
  output logic o_irq,
  output logic o_normal_power,
  output logic [1:0] o_gain,
  output logic [3:0] o_shutter_ma,
  output logic [3:0] o_indicator_ma,
  output logic o_az_busy,
  output logic [3:0] o_az_active
);
  csc_pkg::csc_byte_t setup_one, setup_two, setup_three, setup_four, setup_five;
  csc_pkg::csc_byte_t power_mode_select, irq_pin_setup, ready_signal_enable;
  csc_pkg::csc_byte_t irq_clear_resv, shutter_led_control, indicator_led_control;
  csc_pkg::csc_byte_t gain_and_drive_register;
  logic [2:0] az_resv;
  logic [3:0] az_chan;
  logic az_done_flag;
  logic az_done;
  logic irq_pending;

  // address decode
  wire hit_id = (i_addr == `CSC_ADDR_IDENTITY);
  wire hit_ver = (i_addr == `CSC_ADDR_VERSION);
  wire hit_pwr = (i_addr == `CSC_ADDR_POWER);
  wire hit_pin = (i_addr == `CSC_ADDR_IRQ_PIN);
  wire hit_s1 = (i_addr == `CSC_ADDR_SETUP_ONE);
  wire hit_s2 = (i_addr == `CSC_ADDR_SETUP_TWO);
  wire hit_s3 = (i_addr == `CSC_ADDR_SETUP_THREE);
  wire hit_s4 = (i_addr == `CSC_ADDR_SETUP_FOUR);
  wire hit_s5 = (i_addr == `CSC_ADDR_SETUP_FIVE);
  wire hit_ind = (i_addr == `CSC_ADDR_INDICATOR);
  wire hit_gain = (i_addr == `CSC_ADDR_GAIN_DRIVE);
  wire hit_az = (i_addr == `CSC_ADDR_AUTOZERO);
  wire hit_shut = (i_addr == `CSC_ADDR_SHUTTER);
  wire hit_clr = (i_addr == `CSC_ADDR_IRQ_CLEAR);
  wire hit_rdy = (i_addr == `CSC_ADDR_READY_EN);

  wire wr_az = i_wr && hit_az;
  wire clear_pulse = i_wr && hit_clr && i_wdata[`CSC_CLEAR_BIT];
  wire ready_en = |ready_signal_enable[`CSC_READY_HI:`CSC_READY_LO];
  wire pin_en = (irq_pin_setup == `CSC_IRQ_PIN_ON);

  // field views
  wire shutter_on = shutter_led_control[`CSC_SHUTTER_ON_BIT];
  wire [1:0] shutter_limit = gain_and_drive_register[`CSC_LIMIT_HI:`CSC_LIMIT_LO];
  wire indicator_on = indicator_led_control[`CSC_IND_ON_BIT];
  wire [1:0] indicator_cur = indicator_led_control[`CSC_IND_CUR_HI:`CSC_IND_CUR_LO];

  // bit n of the select is 2^n mA; code 00 is 1 mA
  wire [3:0] indicator_sel = 4'h1 << indicator_cur;
  // bit 0 is 100 mA, halving upward to 12.5 mA at bit 3
  wire [3:0] shutter_sel = 4'h1 << shutter_limit;

  // clear register reads the enable state in the clear bit position
  wire [7:0] clear_view = irq_clear_resv | ({7'h00, ready_en} << `CSC_CLEAR_BIT);
  wire [7:0] az_view = {az_done_flag, az_resv, az_chan};

  // read selection; unmapped addresses read as zero
  wire [7:0] read_mux =
      ({8{hit_id}} & IDENTITY)
    | ({8{hit_ver}} & VERSION)
    | ({8{hit_pwr}} & power_mode_select)
    | ({8{hit_pin}} & irq_pin_setup)
    | ({8{hit_s1}} & setup_one)
    | ({8{hit_s2}} & setup_two)
    | ({8{hit_s3}} & setup_three)
    | ({8{hit_s4}} & setup_four)
    | ({8{hit_s5}} & setup_five)
    | ({8{hit_ind}} & indicator_led_control)
    | ({8{hit_gain}} & gain_and_drive_register)
    | ({8{hit_az}} & az_view)
    | ({8{hit_shut}} & shutter_led_control)
    | ({8{hit_clr}} & clear_view)
    | ({8{hit_rdy}} & ready_signal_enable);

  // setup words are opaque to this block; the host must load them after reset
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      setup_one <= `CSC_SETUP_RST;
      setup_two <= `CSC_SETUP_RST;
      setup_three <= `CSC_SETUP_RST;
      setup_four <= `CSC_SETUP_RST;
      setup_five <= `CSC_SETUP_RST;
    end
    else if (i_wr)
    begin
      if (hit_s1)
        setup_one <= i_wdata;
      if (hit_s2)
        setup_two <= i_wdata;
      if (hit_s3)
        setup_three <= i_wdata;
      if (hit_s4)
        setup_four <= i_wdata;
      if (hit_s5)
        setup_five <= i_wdata;
    end
  end

  // reserved bits are stored as written and rely on the host writing zeros
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      power_mode_select <= `CSC_POWER_RST;
      irq_pin_setup <= `CSC_ZERO_BYTE;
      ready_signal_enable <= `CSC_ZERO_BYTE;
      irq_clear_resv <= `CSC_ZERO_BYTE;
      shutter_led_control <= `CSC_ZERO_BYTE;
      indicator_led_control <= `CSC_ZERO_BYTE;
      gain_and_drive_register <= `CSC_ZERO_BYTE;
    end
    else if (i_wr)
    begin
      if (hit_pwr)
        power_mode_select <= i_wdata;
      if (hit_pin)
        irq_pin_setup <= i_wdata;
      if (hit_rdy)
        ready_signal_enable <= i_wdata;
      if (hit_clr)
        irq_clear_resv <= i_wdata & ~(8'h01 << `CSC_CLEAR_BIT);
      if (hit_shut)
        shutter_led_control <= i_wdata;
      if (hit_ind)
        indicator_led_control <= i_wdata;
      if (hit_gain)
        gain_and_drive_register <= i_wdata;
    end
  end

  // the finishing pass clears start bits even if a write lands in that cycle
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      az_chan <= 4'h0;
      az_resv <= 3'h0;
      az_done_flag <= 1'b0;
    end
    else
    begin
      if (az_done)
        az_chan <= 4'h0;
      else if (wr_az)
        az_chan <= i_wdata[`CSC_AZ_CHAN_HI:`CSC_AZ_CHAN_LO];
      if (wr_az)
        az_resv <= i_wdata[`CSC_AZ_RESV_HI:`CSC_AZ_RESV_LO];
      if (az_done)
        az_done_flag <= 1'b1;
      else if (wr_az)
        az_done_flag <= i_wdata[`CSC_AZ_DONE_BIT];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      o_rdata <= `CSC_ZERO_BYTE;
      o_rvalid <= 1'b0;
    end
    else
    begin
      o_rvalid <= i_rd;
      if (i_rd)
        o_rdata <= read_mux;
    end
  end

  csc_autozero #(
    .CYCLES(AZ_CYCLES),
    .CHANNELS(4)
  ) u_autozero (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_start(az_chan),
    .o_busy(o_az_busy),
    .o_done(az_done),
    .o_active(o_az_active)
  );

  csc_irq u_irq (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_ready_en(ready_en),
    .i_pin_en(pin_en),
    .i_data_ready(i_data_ready),
    .i_clear(clear_pulse),
    .o_pending(irq_pending),
    .o_irq(o_irq)
  );

  assign o_normal_power = power_mode_select[`CSC_NORMAL_BIT];
  assign o_gain = gain_and_drive_register[`CSC_GAIN_HI:`CSC_GAIN_LO];
  assign o_shutter_ma = shutter_on ? shutter_sel : 4'h0;
  assign o_indicator_ma = indicator_on ? indicator_sel : 4'h0;

  default clocking cb @(posedge i_clk); endclocking

  power_reset_a: assert property (i_rst |=> o_normal_power)
    else $error("power mode not normal after reset");

  pin_gate_a: assert property (disable iff (i_rst)
    o_irq |-> irq_pin_setup == `CSC_IRQ_PIN_ON)
    else $error("interrupt asserted with pin disabled");

  clear_read_a: assert property (disable iff (i_rst)
    i_rd && hit_clr && !i_wr |=> o_rvalid && o_rdata[`CSC_CLEAR_BIT] == $past(ready_en))
    else $error("clear bit readback does not follow enable");

  clear_drop_a: assert property (disable iff (i_rst)
    clear_pulse && ready_en && !i_data_ready |=> !o_irq)
    else $error("interrupt survived a clear");

  sequence ready_event_s;
    ready_en && pin_en && i_data_ready && !i_wr;
  endsequence
  sequence irq_seen_s;
    ##1 o_irq;
  endsequence
  ready_irq_a: assert property (disable iff (i_rst)
    ready_event_s |-> irq_seen_s)
    else $error("data-ready did not raise the interrupt");

  shutter_drive_a: assert property (disable iff (i_rst)
    i_wr && hit_shut && !i_wdata[`CSC_SHUTTER_ON_BIT] |=> o_shutter_ma == 4'h0
      ##1 (o_shutter_ma == 4'h0 || $past(i_wr && hit_shut)))
    else $error("shutter output not off after clearing");

  indicator_write_a: assert property (disable iff (i_rst)
    i_wr && hit_ind |=> o_indicator_ma == ($past(i_wdata[`CSC_IND_ON_BIT])
      ? 4'h1 << $past(i_wdata[`CSC_IND_CUR_HI:`CSC_IND_CUR_LO]) : 4'h0))
    else $error("indicator current does not match the written field");

  sequence az_request_s;
    wr_az && |i_wdata[`CSC_AZ_CHAN_HI:`CSC_AZ_CHAN_LO] && !o_az_busy && !az_done;
  endsequence
  sequence az_running_s;
    ##2 o_az_busy;
  endsequence
  az_start_a: assert property (disable iff (i_rst)
    az_request_s |-> az_running_s)
    else $error("auto-zero write did not start a pass");

  az_done_a: assert property (disable iff (i_rst)
    az_done |=> az_done_flag && az_chan == 4'h0)
    else $error("completion flag or start bits wrong after a pass");
endmodule

// ---- bench/csc_host_model.sv ----
// host controller model issuing byte-wide register strobes to the sensor bank
`timescale 1ns/1ns
module csc_host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [7:0] o_wdata
);
  initial
  begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_addr = 8'h00;
    o_wdata = 8'h00;
  end

  // a real host never sets reserved power bits or the calibration flag, so neither do we
  task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] d;
    d = data;
    if (addr == 8'h04)
      d = data & 8'h02;
    if (addr == 8'hba)
      d = data & 8'h7f;
    @(posedge i_clk);
    o_wr <= 1'b1;
    o_addr <= addr;
    o_wdata <= d;
    @(posedge i_clk);
    o_wr <= 1'b0;
  endtask

  // answer is sampled just after the taken edge, the edge at which the bank registers the read strobe
  task automatic read_reg(input logic [7:0] addr, output logic [7:0] data, output logic valid);
    @(posedge i_clk);
    o_rd <= 1'b1;
    o_addr <= addr;
    @(posedge i_clk);
    o_rd <= 1'b0;
    #1;
    data = i_rdata;
    valid = i_rvalid;
  endtask
endmodule

// ---- bench/csc_regs_tb_top.sv ----
// self-checking bench for the colour sensor register bank
`timescale 1ns/1ns
`include "csc_consts.svh"
module csc_regs_tb_top;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rexp;
    logic [3:0] shut;
    logic [3:0] ind;
    logic pwr;
  } csc_row_t;
  localparam int NROWS = 21;
  // short calibration pass keeps the run brief
  localparam int unsigned AZ_N = 4;
  logic clk;
  logic rst;
  logic wr;
  logic rd;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic rvalid;
  logic data_ready;
  logic irq;
  logic normal_power;
  logic [1:0] gain;
  logic [3:0] shutter_ma;
  logic [3:0] indicator_ma;
  logic az_busy;
  logic [3:0] az_active;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  logic [7:0] rv;
  logic vl;
  // setup words carry the values the host must load after reset
  csc_row_t rows [0:NROWS-1] = '{
    '{8'h04, 8'h00, 8'h00, 4'h0, 4'h0, 1'b0},
    '{8'h04, 8'h02, 8'h02, 4'h0, 4'h0, 1'b1},
    '{8'h70, 8'h8a, 8'h8a, 4'h0, 4'h0, 1'b1},
    '{8'h71, 8'h02, 8'h02, 4'h0, 4'h0, 1'b1},
    '{8'hb0, 8'h02, 8'h02, 4'h0, 4'h0, 1'b1},
    '{8'h88, 8'h00, 8'h00, 4'h0, 4'h0, 1'b1},
    '{8'h9a, 8'h02, 8'h02, 4'h0, 4'h0, 1'b1},
    '{8'hea, 8'h04, 8'h04, 4'h1, 4'h0, 1'b1},
    '{8'hb9, 8'h40, 8'h40, 4'h2, 4'h0, 1'b1},
    '{8'hb9, 8'h80, 8'h80, 4'h4, 4'h0, 1'b1},
    '{8'hb9, 8'hc3, 8'hc3, 4'h8, 4'h0, 1'b1},
    '{8'hea, 8'h00, 8'h00, 4'h0, 4'h0, 1'b1},
    '{8'h84, 8'h01, 8'h01, 4'h0, 4'h1, 1'b1},
    '{8'h84, 8'h05, 8'h05, 4'h0, 4'h2, 1'b1},
    '{8'h84, 8'h09, 8'h09, 4'h0, 4'h4, 1'b1},
    '{8'h84, 8'h0d, 8'h0d, 4'h0, 4'h8, 1'b1},
    '{8'h84, 8'h0c, 8'h0c, 4'h0, 4'h0, 1'b1},
    '{8'h01, 8'hff, `CSC_IDENTITY_VALUE, 4'h0, 4'h0, 1'b1},
    '{8'h11, 8'hff, `CSC_VERSION_VALUE, 4'h0, 4'h0, 1'b1},
    '{8'h55, 8'hff, 8'h00, 4'h0, 4'h0, 1'b1},
    '{8'h22, 8'hca, 8'hca, 4'h0, 4'h0, 1'b1}
  };

  csc_regs #(.AZ_CYCLES(AZ_N)) csc_regs_inst (
    .i_clk(clk),
    .i_rst(rst),
    .i_wr(wr),
    .i_rd(rd),
    .i_addr(addr),
    .i_wdata(wdata),
    .o_rdata(rdata),
    .o_rvalid(rvalid),
    .i_data_ready(data_ready),
    .o_irq(irq),
    .o_normal_power(normal_power),
    .o_gain(gain),
    .o_shutter_ma(shutter_ma),
    .o_indicator_ma(indicator_ma),
    .o_az_busy(az_busy),
    .o_az_active(az_active)
  );

  csc_host_model csc_host_model_inst (
    .i_clk(clk),
    .i_rdata(rdata),
    .i_rvalid(rvalid),
    .o_wr(wr),
    .o_rd(rd),
    .o_addr(addr),
    .o_wdata(wdata)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic put(input logic [7:0] a, input logic [7:0] d);
    csc_host_model_inst.write_reg(a, d);
    #1;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    csc_host_model_inst.read_reg(a, rv, vl);
    check({7'h00, vl}, 8'h01);
    check(rv, e);
  endtask

  task automatic pulse_ready();
    @(posedge clk);
    data_ready <= 1'b1;
    @(posedge clk);
    data_ready <= 1'b0;
    #1;
  endtask

  // waits for a pass to start, then counts how long it stays busy
  task automatic az_wait(input logic [3:0] chans);
    int n;
    n = 0;
    #1;
    while (az_busy !== 1'b1 && n < 10)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check(8'(az_busy), 8'h01);
    check(8'(az_active), 8'(chans));
    n = 0;
    while (az_busy === 1'b1 && n < 20)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    check(n[7:0], AZ_N[7:0]);
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 4000)
    begin
      failures++;
      tally_and_finish();
    end
  end

  initial
  begin
    rst = 1'b1;
    data_ready = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    #1;
    check(8'(normal_power), 8'h01);
    check(8'(irq), 8'h00);
    rd_chk(8'h04, 8'h02);
    rd_chk(8'h22, 8'h00);
    rd_chk(8'hba, 8'h00);
    $display("test reset done");
    for (int i = 0; i < NROWS; i++)
    begin
      put(rows[i].addr, rows[i].wdata);
      check(8'(shutter_ma), 8'(rows[i].shut));
      check(8'(indicator_ma), 8'(rows[i].ind));
      check(8'(normal_power), 8'(rows[i].pwr));
      rd_chk(rows[i].addr, rows[i].rexp);
    end
    check(8'(gain), 8'h03);
    $display("test table done");
    // ready reporting still off: the event must be dropped
    pulse_ready();
    check(8'(irq), 8'h00);
    rd_chk(8'hf8, 8'h00);
    put(8'hf9, 8'h02);
    rd_chk(8'hf8, 8'h04);
    pulse_ready();
    check(8'(irq), 8'h01);
    repeat (3) @(posedge clk);
    #1;
    check(8'(irq), 8'h01);
    put(8'h22, 8'h00);
    check(8'(irq), 8'h00);
    put(8'h22, 8'hca);
    check(8'(irq), 8'h01);
    put(8'hf9, 8'h00);
    put(8'hf8, 8'h04);
    put(8'hf9, 8'h04);
    check(8'(irq), 8'h01);
    put(8'hf8, 8'h04);
    check(8'(irq), 8'h00);
    $display("test interrupt done");
    put(8'hba, 8'h8f);
    az_wait(4'hf);
    rd_chk(8'hba, 8'h80);
    // cleared start bits must not launch a second pass
    check(8'(az_busy), 8'h00);
    put(8'hba, 8'h05);
    az_wait(4'h5);
    rd_chk(8'hba, 8'h80);
    check(8'(az_busy), 8'h00);
    put(8'hba, 8'h00);
    rd_chk(8'hba, 8'h00);
    $display("test calibration done");
    // mid-run reset must bring back defaults over non-default contents
    put(8'h04, 8'h00);
    put(8'hea, 8'h04);
    check(8'(normal_power), 8'h00);
    check(8'(shutter_ma), 8'h08);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    check(8'(normal_power), 8'h01);
    check(8'(shutter_ma), 8'h00);
    check(8'(irq), 8'h00);
    rd_chk(8'hf9, 8'h00);
    rd_chk(8'h22, 8'h00);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule
